// ===== match_counter.sv
// Counter core: gated count, compare match and clear
module match_counter #(
   parameter int WIDTH = 16
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic countTick,
   input wire logic loadEn,
   input wire logic [WIDTH-1:0] loadValue,
   input wire logic [WIDTH-1:0] compareValue,
   output logic [WIDTH-1:0] count,
   output logic matchPulse
);
   initial
   begin
      if (WIDTH < 2 || WIDTH > 32) $error("match_counter: WIDTH out of range");
   end

   wire logic hitNow = countTick && (count == compareValue);
   wire logic [WIDTH-1:0] next_count = hitNow ? '0 : count + WIDTH'(1);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         count <= '0;
         matchPulse <= 1'b0;
      end
      else
      begin
         matchPulse <= hitNow;
         // [R12] load
         if (loadEn)
            count <= loadValue;
         // [R17] count up
         else if (countTick)
            count <= next_count;
      end
   end
endmodule

// ===== match_timer_checker.sv
// Checker: bus and output timing of the match timer
module match_timer_checker #(
   parameter int COUNT_WIDTH = 16
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [1:0] s_axi_rresp,
   input wire logic square_wave_out,
   input wire logic match_irq
);
   import match_timer_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ------
   // Assertions
   // ------
   AST_RST_LOW: assert property ($past(rst) |-> !square_wave_out && !match_irq)
      else $error("output or irq high after reset");
   AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_WR_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   // Irq may only drop after a write cleared status or mask
   AST_IRQ_CLEAR: assert property ($fell(match_irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("irq dropped without a write");
   AST_TOGGLE_GAP: assert property ($changed(square_wave_out) |=> $stable(square_wave_out))
      else $error("output changed twice in a row");
   COV_IRQ: cover property ($rose(match_irq));
   COV_WAVE: cover property ($changed(square_wave_out));
   COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

// ===== match_timer_pkg.sv
// Package: register map, field layout and reset values of the match timer
package match_timer_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_RUN = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_COMPARE = 8'h0C;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_IDLE_KEEP = 0;
   localparam int BIT_HALT_STOP = 1;
   localparam int BIT_RUN = 0;
   localparam int BIT_CLK_SEL = 0;
   localparam int BIT_FORCE_LO = 4;
   localparam int BIT_FORCE_HI = 5;
   localparam int BIT_TOGGLE_EN = 7;
   localparam int BIT_MUST_SET = 15;
   localparam int BIT_IRQ_MATCH = 0;
   // ----------------------------------------
   // Reset values and encodings
   // ----------------------------------------
   localparam logic [1:0] RST_ENABLE = 2'h0;
   localparam logic [15:0] RST_COMPARE = 16'h0000;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [1:0] FORCE_INVERT = 2'h0;
   localparam logic [1:0] FORCE_SET = 2'h1;
   localparam logic [1:0] FORCE_CLEAR = 2'h2;
   localparam logic [1:0] FORCE_NONE = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== match_timer_unit.sv
// Top: 16-bit match timer with AXI4-Lite register slave
//
// Contract
// [R1] Software changes setup only while stopped
// [R2] Enable bit1 stops counting in debug halt
// [R3] Enable bit0 keeps counting while idle
// [R4] Run bit0 starts/stops, reads back
// [R5] Software sets control bit15 before start
// [R6] Control bit7 toggles output on match
// [R7] Force field acts at once, reads 11
// [R8] Control bit0 selects count clock source
// [R9] Compare value 16 bits, upper zero
// [R10] Software never programs compare zero
// [R11] Count read returns live value
// [R12] Count write loads counter
// [R13] Clear on match only; continue counting
// [R14] Match raises interrupt request
// [R15] Output low after reset
// [R16] Stop holds count and output; a match in the stop cycle still toggles the output two edges later
// [R17] Increment per tick of selected source
//
// Design decision made here: the AXI4-Lite interface to the registers.
module match_timer_unit #(
   parameter int COUNT_WIDTH = 16
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic periphTick,
   input wire logic idleMode,
   input wire logic debugHalt,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic square_wave_out,
   output logic match_irq
);
   import match_timer_pkg::*;

   initial
   begin
      if (COUNT_WIDTH != 16) $error("match_timer_unit: COUNT_WIDTH must be 16");
   end

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic idleKeep;
   logic haltStop;
   logic runBit;
   logic clkSel;
   logic toggleEn;
   logic mustSet;
   logic [15:0] compareValue;
   logic irqStatus;
   logic irqMask;
   logic [15:0] count;
   logic matchPulse;
   logic waveOut;

   // ----------------------------------------
   // Write channel
   // ----------------------------------------
   logic awHeld;
   logic wHeld;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;

   wire logic awTake = s_axi_awvalid && s_axi_awready;
   wire logic wTake = s_axi_wvalid && s_axi_wready;
   wire logic writeFire = awHeld && wHeld && !s_axi_bvalid;
   wire logic lane0 = wStrb[0];
   wire logic lane1 = wStrb[1];
   wire logic hitEnable = awAddr == OFS_ENABLE;
   wire logic hitRun = awAddr == OFS_RUN;
   wire logic hitControl = awAddr == OFS_CONTROL;
   wire logic hitCompare = awAddr == OFS_COMPARE;
   wire logic hitCount = awAddr == OFS_COUNT;
   wire logic hitStatus = awAddr == OFS_IRQ_STATUS;
   wire logic hitMask = awAddr == OFS_IRQ_MASK;
   wire logic writeMapped = hitEnable || hitRun || hitControl || hitCompare || hitCount || hitStatus || hitMask;
   wire logic wrEnable = writeFire && hitEnable && lane0;
   wire logic wrRun = writeFire && hitRun && lane0;
   wire logic wrControlLo = writeFire && hitControl && lane0;
   wire logic wrControlHi = writeFire && hitControl && lane1;
   wire logic wrStatus = writeFire && hitStatus && lane0;
   wire logic wrMask = writeFire && hitMask && lane0;
   // [R12] count load
   wire logic loadEn = writeFire && hitCount && (lane0 || lane1);
   wire logic [15:0] loadValue = {lane1 ? wData[15:8] : count[15:8], lane0 ? wData[7:0] : count[7:0]};
   // [R7] force strobe on write
   wire logic forceStrobe = wrControlLo;
   wire logic [1:0] forceCmd = wData[BIT_FORCE_HI:BIT_FORCE_LO];

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         if (awTake)
         begin
            awHeld <= 1'b1;
            awAddr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (wTake)
         begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (writeFire)
         begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeMapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         {haltStop, idleKeep} <= RST_ENABLE;
         runBit <= 1'b0;
         clkSel <= 1'b0;
         toggleEn <= 1'b0;
         mustSet <= 1'b0;
         compareValue <= RST_COMPARE;
         irqMask <= 1'b0;
      end
      else
      begin
         if (wrEnable)
         begin
            idleKeep <= wData[BIT_IDLE_KEEP];
            haltStop <= wData[BIT_HALT_STOP];
         end
         // [R4] run bit
         if (wrRun)
            runBit <= wData[BIT_RUN];
         if (wrControlLo)
         begin
            clkSel <= wData[BIT_CLK_SEL];
            toggleEn <= wData[BIT_TOGGLE_EN];
         end
         // [R5] stored, read back
         if (wrControlHi)
            mustSet <= wData[BIT_MUST_SET];
         // [R9] compare bytes
         if (writeFire && hitCompare && lane0)
            compareValue[7:0] <= wData[7:0];
         if (writeFire && hitCompare && lane1)
            compareValue[15:8] <= wData[15:8];
         if (wrMask)
            irqMask <= wData[BIT_IRQ_MATCH];
      end
   end

   // ----------------------------------------
   // Count gating
   // ----------------------------------------
   // [R3] idle suspend
   wire logic idleBlock = idleMode && !idleKeep;
   // [R2] halt suspend
   wire logic haltBlock = debugHalt && haltStop;
   // [R8] source select
   wire logic srcTick = clkSel ? periphTick : 1'b1;
   // [R16] no ticks while stopped
   wire logic countTick = runBit && !idleBlock && !haltBlock && srcTick;

   // [R13] clear on match
   match_counter #(
      .WIDTH(16)
   ) u_counter (
      .clk_sys(clk_sys),
      .rst(rst),
      .countTick(countTick),
      .loadEn(loadEn),
      .loadValue(loadValue),
      .compareValue(compareValue),
      .count(count),
      .matchPulse(matchPulse)
   );

   square_wave_gen u_wave (
      .clk_sys(clk_sys),
      .rst(rst),
      .toggleEn(toggleEn),
      .matchPulse(matchPulse),
      .forceStrobe(forceStrobe),
      .forceCmd(forceCmd),
      .waveOut(waveOut)
   );

   assign square_wave_out = waveOut;

   // ----------------------------------------
   // Interrupt
   // ----------------------------------------
   // Set beats the write-one clear
   wire logic next_status = matchPulse || (irqStatus && !(wrStatus && wData[BIT_IRQ_MATCH]));

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         irqStatus <= 1'b0;
         match_irq <= 1'b0;
      end
      else
      begin
         // [R14] match sets status
         irqStatus <= next_status;
         match_irq <= next_status && irqMask;
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   wire logic [7:0] rdAddr = {s_axi_araddr[7:2], 2'b00};
   wire logic arTake = s_axi_arvalid && s_axi_arready;
   logic [31:0] rdWord;
   logic rdMapped;

   always_comb
   begin
      rdWord = 32'h0000_0000;
      rdMapped = 1'b1;
      unique case (rdAddr)
         OFS_ENABLE: rdWord = {30'h0, haltStop, idleKeep};
         OFS_RUN: rdWord = {31'h0, runBit};
         // [R7] force field reads 11
         OFS_CONTROL: rdWord = {16'h0, mustSet, 7'h0, toggleEn, 1'b0, FORCE_NONE, 3'h0, clkSel};
         OFS_COMPARE: rdWord = {16'h0, compareValue};
         // [R11] live count
         OFS_COUNT: rdWord = {16'h0, count};
         OFS_IRQ_STATUS: rdWord = {31'h0, irqStatus};
         OFS_IRQ_MASK: rdWord = {31'h0, irqMask};
         default: rdMapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (arTake)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdWord;
         s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   assign s_axi_arready = !s_axi_rvalid;
endmodule

// ===== sixteen_bit_match_timer_tb.sv
// Testbench: register bus, counting, output and interrupt checks
module sixteen_bit_match_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import match_timer_pkg::*;
   logic clk_sys = 1'h0, rst = 1'h1, periphTick = 1'h0, idleMode = 1'h0, debugHalt = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, prevOut = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, seed = 32'h00014380, rdata;
   logic awready, wready, bvalid, arready, rvalid, waveOut, irq;
   logic [1:0] bresp, rresp;
   logic [33:0] expQ[$];
   logic [1:0] fc[5] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h3};
   logic fo[5] = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1};
   // Case bits: run expected, halt, idle, enable field
   logic [4:0] tc[4] = '{5'h04, 5'h15, 5'h0A, 5'h18};
   int n_errors = 0, checked = 0, cyc = 0, lastT = 0, gap = 0, nTog = 0;

   always #10 clk_sys = ~clk_sys;

   match_timer_unit #(.COUNT_WIDTH(16)) dut (.clk_sys(clk_sys), .rst(rst), .periphTick(periphTick),
      .idleMode(idleMode), .debugHalt(debugHalt), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .square_wave_out(waveOut),
      .match_irq(irq));
   // ------
   // Tasks
   // ------
   task results();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task chk(input logic [33:0] s, input logic [33:0] e);
      checked++;
      if (s !== e)
      begin
         n_errors++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge clk_sys);
         if (awready === 1'h1)
            awvalid <= 1'h0;
         if (wready === 1'h1)
            wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk(bresp, (a > OFS_IRQ_MASK) ? RESP_SLVERR : RESP_OKAY);
   endtask

   task rd(input logic [7:0] a, input logic [33:0] e);
      expQ.push_back(e);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge clk_sys);
         if (arready === 1'h1)
            arvalid <= 1'h0;
      end
      while (rvalid !== 1'h1);
      rready <= 1'h0;
   endtask

   always @(posedge clk_sys)
   begin
      cyc++;
      if (rvalid === 1'h1 && rready === 1'h1)
         chk({rresp, rdata}, expQ.pop_front());
      if (waveOut !== prevOut)
      begin
         gap = cyc - lastT;
         lastT = cyc;
         nTog++;
      end
      prevOut = waveOut;
      // Tick every third cycle, so gaps scale by three
      periphTick <= (cyc % 3 == 0);
      if (cyc > 20000)
      begin
         n_errors++;
         results();
      end
   end
   // ------
   // Sequence
   // ------
   initial
   begin
      logic [31:0] r;
      int c;
      repeat (2) @(posedge clk_sys);
      rst <= 1'h0;
      @(negedge clk_sys);
      chk({waveOut, irq}, 2'h0);
      for (int i = 0; i < 7; i++)
         rd(8'(4 * i), (i == 2) ? 34'h30 : 34'h0);
      rd(8'h1C, {RESP_SLVERR, 32'h0});
      wr(8'h1C, xs());
      r = xs();
      wr(OFS_ENABLE, r);
      rd(OFS_ENABLE, {2'h0, r & 32'h3});
      r = xs() & 32'hFFFFFFFE;
      wr(OFS_RUN, r);
      rd(OFS_RUN, 34'h0);
      // Force field kept at 11 so setup leaves the output alone
      r = xs() | 32'h30;
      wr(OFS_CONTROL, r);
      rd(OFS_CONTROL, {2'h0, r & 32'h80B1});
      r = xs();
      wr(OFS_COMPARE, r);
      rd(OFS_COMPARE, {2'h0, r & 32'hFFFF});
      r = xs();
      wr(OFS_COUNT, r);
      rd(OFS_COUNT, {2'h0, r & 32'hFFFF});
      for (int i = 0; i < 5; i++)
      begin
         wr(OFS_CONTROL, {24'h80, 2'h0, fc[i], 4'h0});
         @(negedge clk_sys);
         chk(waveOut, fo[i]);
      end
      for (int s = 0; s < 2; s++)
      begin
         c = xs() % 8 + 3;
         wr(OFS_COMPARE, 32'(c));
         wr(OFS_COUNT, 32'h0);
         wr(OFS_CONTROL, 32'h80B0 | 32'(s));
         wr(OFS_RUN, 32'h1);
         repeat (100) @(negedge clk_sys);
         chk(34'(gap), 34'((c + 1) * (2 * s + 1)));
         wr(OFS_RUN, 32'h0);
      end
      wr(OFS_COMPARE, 32'h3);
      wr(OFS_CONTROL, 32'h80B0);
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_ENABLE, {30'h0, tc[i][1:0]});
         wr(OFS_COUNT, 32'h0);
         idleMode <= tc[i][2];
         debugHalt <= tc[i][3];
         c = nTog;
         wr(OFS_RUN, 32'h1);
         repeat (30) @(negedge clk_sys);
         chk(nTog != c, tc[i][4]);
         wr(OFS_RUN, 32'h0);
         // Match in the stop cycle still toggles two edges later
         repeat (3) @(negedge clk_sys);
         c = nTog;
         repeat (20) @(negedge clk_sys);
         chk(34'(nTog), 34'(c));
      end
      idleMode <= 1'h0;
      debugHalt <= 1'h0;
      @(negedge clk_sys);
      chk(irq, 1'h0);
      rd(OFS_IRQ_STATUS, 34'h1);
      wr(OFS_IRQ_MASK, 32'h1);
      @(negedge clk_sys);
      chk(irq, 1'h1);
      wr(OFS_IRQ_STATUS, 32'h1);
      @(negedge clk_sys);
      chk(irq, 1'h0);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_RUN, 32'h1);
      repeat (30) @(negedge clk_sys);
      chk(irq, 1'h1);
      wr(OFS_RUN, 32'h0);
      results();
   end
endmodule

bind match_timer_unit match_timer_checker #(.COUNT_WIDTH(COUNT_WIDTH)) checker_i (.clk_sys, .rst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .square_wave_out, .match_irq);

// ===== square_wave_gen.sv
// Square wave output: toggle on match, software force
module square_wave_gen (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic toggleEn,
   input wire logic matchPulse,
   input wire logic forceStrobe,
   input wire logic [1:0] forceCmd,
   output logic waveOut
);
   import match_timer_pkg::*;

   logic next_wave;

   always_comb
   begin
      next_wave = waveOut;
      // [R6] toggle on match
      if (toggleEn && matchPulse)
         next_wave = ~waveOut;
      // [R7] software force
      if (forceStrobe)
      begin
         unique case (forceCmd)
            FORCE_INVERT: next_wave = ~waveOut;
            FORCE_SET: next_wave = 1'b1;
            FORCE_CLEAR: next_wave = 1'b0;
            FORCE_NONE: next_wave = next_wave;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      // [R15] low after reset
      if (rst)
         waveOut <= 1'b0;
      // [R16] level held otherwise
      else
         waveOut <= next_wave;
   end
endmodule
